// *** hdl/sldrv_driver.sv ***
// driver end: shifts serial frames in and latches the segment outputs
`include "sldrv_defines.svh"
module sldrv_driver
  import sldrv_pkg::*;
#(
  parameter bit HAS_ENABLE = 1'b0  // data-enable variant, 34 outputs
)(
  input  wire logic                        core_clk, // system clock
  input  wire logic                        reset_n,  // sync reset, active low
  input  wire logic                        clk_en,   // freezes all state when low
  sldrv_link_if.driver                     link,     // serial link
  output logic [`SLDRV_DATA_BITS-1:0]      seg_on    // bit 0 is output 1, high lights
);
  // three-stage synchronisers; stage 1 read only by stage 2
  logic [2:0] dat_sync_reg, dat_sync_next;
  logic [2:0] sck_sync_reg, sck_sync_next;
  logic [2:0] en_sync_reg,  en_sync_next;
  logic       sck_lvl_reg,  sck_lvl_next;
  logic       dat_lvl_reg,  dat_lvl_next;
  logic       en_lvl_reg,   en_lvl_next;
  logic [`SLDRV_FRAME_BITS-1:0] chain_reg, chain_next;
  logic [`SLDRV_DATA_BITS-1:0]  latch_reg, latch_next;
  logic                         rise;
  logic                         accept;
  logic [`SLDRV_FRAME_BITS-1:0] shifted;

  always_comb
  begin
    dat_sync_next = {dat_sync_reg[1:0], link.ser_data};
    sck_sync_next = {sck_sync_reg[1:0], link.ser_clk};
    en_sync_next  = {en_sync_reg[1:0],  link.data_en};
    // a level counts once stages two and three agree
    sck_lvl_next = (sck_sync_reg[1] == sck_sync_reg[2]) ? sck_sync_reg[2] : sck_lvl_reg;
    dat_lvl_next = (dat_sync_reg[1] == dat_sync_reg[2]) ? dat_sync_reg[2] : dat_lvl_reg;
    en_lvl_next  = (en_sync_reg[1] == en_sync_reg[2])   ? en_sync_reg[2]  : en_lvl_reg;
  end

  assign rise    = sck_lvl_next & ~sck_lvl_reg;
  assign accept  = rise & (~HAS_ENABLE | en_lvl_reg);
  assign shifted = {chain_reg[`SLDRV_FRAME_BITS-2:0], dat_lvl_reg};

  always_comb
  begin
    chain_next = chain_reg;
    latch_next = latch_reg;
    if (accept)
    begin
      if (shifted[`SLDRV_FRAME_BITS-1])
      begin
        // start bit reached the end: 36th clock, load then clear
        latch_next = shifted[`SLDRV_DATA_BITS-1:0];
        // clearing on the same step keeps no stale stage; the next
        // bit is taken fresh, so frames can follow back to back
        chain_next = '0;
      end
      else
      begin
        chain_next = shifted;
      end
    end
  end

  // first data bit sits deepest, so reverse order onto outputs
  genvar g;
  generate
    for (g = 0; g < `SLDRV_DATA_BITS; g++)
    begin : g_out
      if (HAS_ENABLE && g == `SLDRV_DATA_BITS - 1)
      begin : g_none
        assign seg_on[g] = 1'b0;
      end
      else
      begin : g_drv
        assign seg_on[g] = latch_reg[`SLDRV_DATA_BITS-1-g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      dat_sync_reg <= '0;
      sck_sync_reg <= '0;
      en_sync_reg  <= '0;
      sck_lvl_reg  <= 1'b0;
      dat_lvl_reg  <= 1'b0;
      en_lvl_reg   <= 1'b0;
      chain_reg    <= '0;
      latch_reg    <= '0;
    end
    else if (clk_en)
    begin
      dat_sync_reg <= dat_sync_next;
      sck_sync_reg <= sck_sync_next;
      en_sync_reg  <= en_sync_next;
      sck_lvl_reg  <= sck_lvl_next;
      dat_lvl_reg  <= dat_lvl_next;
      en_lvl_reg   <= en_lvl_next;
      chain_reg    <= chain_next;
      latch_reg    <= latch_next;
    end
  end
endmodule

// *** hdl/sldrv_source.sv ***
// data source end: frames 35 bits behind a start one and clocks them out
`include "sldrv_defines.svh"
module sldrv_source
  import sldrv_pkg::*;
#(
  parameter int HALF_CYCLES = `SLDRV_HALF_CYCLES
)(
  input  wire logic                        core_clk,  // system clock
  input  wire logic                        reset_n,   // sync reset, active low
  input  wire logic                        clk_en,    // freezes all state when low
  input  wire logic                        send_valid, // frame request
  input  wire logic [`SLDRV_DATA_BITS-1:0] send_bits, // bit 0 goes to output 1
  output logic                             send_ready, // idle, may take request
  sldrv_link_if.source                     link       // serial link
);
  sldrv_src_state_t                 state_reg, state_next;
  logic [`SLDRV_FRAME_BITS-1:0]     shift_reg, shift_next;
  logic [`SLDRV_CNT_W-1:0]          cnt_reg, cnt_next;
  logic [`SLDRV_DIV_W-1:0]          div_reg, div_next;
  logic                             dat_reg, dat_next;
  logic                             sck_reg, sck_next;
  logic                             en_reg, en_next;

  assign send_ready    = (state_reg == SLDRV_IDLE);
  assign link.ser_data = dat_reg;
  assign link.ser_clk  = sck_reg;
  assign link.data_en  = en_reg;

  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    div_next   = div_reg;
    dat_next   = dat_reg;
    sck_next   = sck_reg;
    en_next    = en_reg;
    case (state_reg)
      SLDRV_IDLE:
      begin
        sck_next = 1'b0;
        if (send_valid)
        begin
          shift_next = {send_bits, 1'b1};
          cnt_next   = '0;
          div_next   = '0;
          en_next    = 1'b1;
          state_next = SLDRV_LOW;
        end
        else
        begin
          en_next = 1'b0;
        end
      end
      SLDRV_LOW:
      begin
        dat_next = shift_reg[0];
        if (div_reg == `SLDRV_DIV_W'(HALF_CYCLES - 1))
        begin
          div_next   = '0;
          sck_next   = 1'b1;
          state_next = SLDRV_HIGH;
        end
        else
        begin
          div_next = div_reg + 1'b1;
        end
      end
      SLDRV_HIGH:
      begin
        if (div_reg == `SLDRV_DIV_W'(HALF_CYCLES - 1))
        begin
          div_next   = '0;
          sck_next   = 1'b0;
          shift_next = {1'b0, shift_reg[`SLDRV_FRAME_BITS-1:1]};
          // always a full set of clocks, never a partial frame
          if (cnt_reg == `SLDRV_CNT_W'(`SLDRV_FRAME_BITS - 1))
          begin
            state_next = SLDRV_IDLE;
          end
          else
          begin
            cnt_next   = cnt_reg + 1'b1;
            state_next = SLDRV_LOW;
          end
        end
        else
        begin
          div_next = div_reg + 1'b1;
        end
      end
      default:
      begin
        state_next = SLDRV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= SLDRV_IDLE;
      shift_reg <= '0;
      cnt_reg   <= '0;
      div_reg   <= '0;
      dat_reg   <= 1'b0;
      sck_reg   <= 1'b0;
      en_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      div_reg   <= div_next;
      dat_reg   <= dat_next;
      sck_reg   <= sck_next;
      en_reg    <= en_next;
    end
  end
endmodule

// *** include/sldrv_defines.svh ***
// constants for the serial led segment latch driver link
// Contract
// - two signals only: data and clock
// - source sends start one then 35 bits
// - latch 35 bits after 36th bit completes
// - latches hold between frames
// - 36th clock makes latch-transfer pulse
// - clear pulse empties shift chain afterwards
// - first stage master survives clear, back-to-back (driver clears the whole chain on the load step; the next bit shifts in fresh)
// - source must give full 36 clocks
// - power-up reset clears chain and latches
// - start bit and clock resume reception
// - first data bit drives output one
// - latched one turns output on
// - enable variant drops 35th output
// - serial clock at most 0.5 MHz
`ifndef SLDRV_DEFINES_SVH
`define SLDRV_DEFINES_SVH
`define SLDRV_DATA_BITS      35
`define SLDRV_FRAME_BITS     36
`define SLDRV_CNT_W          6
`define SLDRV_MAX_CLK_KHZ    500
`define SLDRV_CORE_CLK_KHZ   100000
// half period of the serial clock in core cycles, rounded up (least time)
`define SLDRV_HALF_CYCLES    ((`SLDRV_CORE_CLK_KHZ + 2 * `SLDRV_MAX_CLK_KHZ - 1) / (2 * `SLDRV_MAX_CLK_KHZ))
`define SLDRV_DIV_W          8
`endif

// *** include/sldrv_link_if.sv ***
// two-wire serial link plus optional data enable
interface sldrv_link_if;
  logic ser_data;
  logic ser_clk;
  logic data_en;
  modport source (output ser_data, output ser_clk, output data_en);
  modport driver (input ser_data, input ser_clk, input data_en);
endinterface

// *** include/sldrv_pkg.sv ***
// types shared by both ends of the serial led driver link
package sldrv_pkg;
  typedef enum logic [1:0] {
    SLDRV_IDLE  = 2'b00,
    SLDRV_LOW   = 2'b01,
    SLDRV_HIGH  = 2'b10
  } sldrv_src_state_t;
endpackage

// *** sim/serial_led_segment_latch_driver_tb.sv ***
// bench: source and driver back to back, bench-driven second driver
`include "sldrv_defines.svh"
module serial_led_segment_latch_driver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        send_valid = 1'b0;
  logic [34:0] send_bits = '0;
  logic        send_ready;
  logic [34:0] seg_a;
  logic [34:0] seg_b;
  logic [34:0] v;
  logic [34:0] pat [4] = '{35'h7ffffffff, 35'h0, 35'h1, 35'h555555555};
  int          fails = 0;
  int          check_count = 0;
  int          seed = 86;
  int          i;
  sldrv_link_if link_a ();
  sldrv_link_if link_b ();
  sldrv_source #(.HALF_CYCLES(4)) u_sldrv_source (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(1'b1), .send_valid(send_valid), .send_bits(send_bits),
    .send_ready(send_ready), .link(link_a));
  sldrv_driver u_sldrv_driver (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .link(link_a), .seg_on(seg_a));
  sldrv_driver #(.HAS_ENABLE(1'b1)) u_sldrv_driver_b (.core_clk(core_clk),
    .reset_n(reset_n), .clk_en(1'b1), .link(link_b), .seg_on(seg_b));
  sldrv_link_assertions u_sldrv_link_assertions (.core_clk(core_clk), .reset_n(reset_n),
    .ser_data(link_a.ser_data), .ser_clk(link_a.ser_clk), .data_en(link_a.data_en),
    .seg_on(seg_a));
  always #5 core_clk = ~core_clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [34:0] got, input logic [34:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [34:0] exp_seg(input logic [34:0] b, input bit en);
    return en ? {1'b0, b[33:0]} : b;
  endfunction
  task automatic send(input logic [34:0] b);
    int n;
    send_valid = 1'b1;
    send_bits = b;
    @(posedge core_clk);
    #1 send_valid = 1'b0;
    for (n = 0; n < 400 && send_ready !== 1'b1; n++)
      @(posedge core_clk) #1;
    if (n == 400)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  // far side stand-in for the second driver; clk stays low between frames
  task automatic frame_b(input logic [34:0] b, input int cnt);
    int k;
    for (k = 0; k < cnt; k++)
    begin
      link_b.ser_data = (k == 0) ? 1'b1 : b[k-1];
      repeat (4) @(posedge core_clk);
      #1 link_b.ser_clk = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 link_b.ser_clk = 1'b0;
    end
    link_b.ser_data = ~link_b.ser_data;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  initial
  begin
    link_b.ser_data = 1'b0;
    link_b.ser_clk = 1'b0;
    link_b.data_en = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 reset_n = 1'b1;
    cmp(seg_a, 35'h0);
    for (i = 0; i < 10; i++)
    begin
      v = (i < 4) ? pat[i] : 35'({$random(seed), $random(seed)});
      send(v);
      cmp(seg_a, exp_seg(v, 1'b0));
    end
    frame_b(pat[0], 36);
    cmp(seg_b, exp_seg(pat[0], 1'b1));
    frame_b(pat[1], 20);
    cmp(seg_b, exp_seg(pat[0], 1'b1));
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 cmp(seg_b, 35'h0);
    cmp(seg_a, 35'h0);
    reset_n = 1'b1;
    link_b.data_en = 1'b0;
    frame_b(pat[0], 36);
    cmp(seg_b, 35'h0);
    link_b.data_en = 1'b1;
    frame_b(35'h2, 36);
    cmp(seg_b, 35'h2);
    tally_and_finish();
  end
endmodule

// *** sim/sldrv_link_assertions.sv ***
// link checker: frame shape and latch timing
`include "sldrv_defines.svh"
module sldrv_link_assertions (
  input wire logic        core_clk, // clock
  input wire logic        reset_n,  // reset
  input wire logic        ser_data, // data
  input wire logic        ser_clk,  // link clock
  input wire logic        data_en,  // enable
  input wire logic [34:0] seg_on    // outputs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [5:0]  rise_cnt;
  logic [34:0] shadow;
  logic        clk_prev;
  // own chain copy, so a misordered load shows
  // count restarts after 36 so back-to-back frames with enable held still line up
  always_ff @(posedge core_clk)
  begin
    clk_prev <= ser_clk;
    if (!reset_n || !data_en)
      rise_cnt <= 6'h00;
    else if (ser_clk && !clk_prev)
    begin
      rise_cnt <= (rise_cnt == 6'h24) ? 6'h01 : rise_cnt + 6'h01;
      shadow   <= {ser_data, shadow[34:1]};
    end
  end
  sequence last_rise;
    $rose(ser_clk) && rise_cnt == 6'h23;
  endsequence
  chk_clk_high_len: assert property ($rose(ser_clk) |-> ser_clk[*4])
    else $error("clock high too short");
  chk_clk_low_len: assert property ($fell(ser_clk) |-> !ser_clk[*4])
    else $error("clock low too short");
  chk_data_hold: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_data))
    else $error("data moved in high phase");
  chk_idle_clk_low: assert property (!data_en |-> !ser_clk)
    else $error("clock outside frame");
  chk_start_one: assert property ($rose(ser_clk) && (rise_cnt == 6'h00 || rise_cnt == 6'h24) |-> ser_data)
    else $error("start bit not one");
  chk_rise_count: assert property ($fell(data_en) |-> rise_cnt == 6'h24)
    else $error("frame clock count");
  chk_load_moment: assert property ($changed(seg_on) |-> rise_cnt == 6'h24)
    else $error("outputs moved mid frame");
  chk_load_value: assert property (last_rise |-> ##[2:6] seg_on == shadow)
    else $error("latched value wrong");
endmodule
